// >>> rtl/adcsq_top.sv
// Converter control, sequencing and register file behind an Avalon-MM slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module adcsq_top
   import adcsq_pkg::*;
#(
   parameter int RES_W = 9                          // Result width
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Avalon-MM slave, byte addressed
   input  wire logic [9:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   // Analog front end
   input  wire logic             cmp_above,         // Sampled input at or above trial level
   output logic                  adc_power_on,
   output logic      [1:0]       analog_sel,
   output logic                  sample_hold,
   output logic      [RES_W-1:0] trial_code,
   // Port B pin control
   output logic      [3:0]       analog_pin_mask,   // High: pin is analog, digital and pull-high off
   // Interrupt request to the processor
   output logic                  conv_irq
);

   // Register state
   logic [7:0]       ctl_q;                         // Control register
   logic [7:0]       ctl_d;
   logic [1:0]       div_sel_q;                     // Conversion clock select
   logic             test_bit_q;                    // Factory test bit, stored only
   logic             irq_en_q;                      // Converter interrupt enable
   logic             irq_gen_q;                     // Global interrupt enable
   logic             irq_req_q;                     // Converter interrupt request
   logic [RES_W-1:0] result_q;                      // Last conversion result

   // Bus handshake state
   logic             wait_q;                        // Registered waitrequest
   logic [31:0]      rdata_q;                       // Registered read data

   // Sequencer state
   adcsq_state_t     state_q;
   adcsq_state_t     state_d;
   logic [5:0]       div_cnt_q;                     // System clocks within a period
   logic [6:0]       tad_q;                         // Conversion periods since start
   logic [1:0]       sub_q;                         // Periods within one bit trial
   logic [3:0]       bit_q;                         // Bit under trial
   logic [RES_W-1:0] sar_q;                         // Successive approximation word
   logic             pwr_q;
   logic [3:0]       pin_mask_q;
   logic             irq_q;

   // Address decode
   wire              wr_go      = avs_write & ~wait_q;
   wire              hit_lo     = (avs_address == {IDX_RESULT_LOW, 2'b00});
   wire              hit_hi     = (avs_address == {IDX_RESULT_HIGH, 2'b00});
   wire              hit_ctl    = (avs_address == {IDX_CONTROL, 2'b00});
   wire              hit_clk    = (avs_address == {IDX_CLOCK_SETTING, 2'b00});
   wire              hit_irq    = (avs_address == {IDX_IRQ_CTRL, 2'b00});
   wire              wr_ctl     = wr_go & hit_ctl;
   wire              wr_clk     = wr_go & hit_clk;
   wire              wr_irq     = wr_go & hit_irq;

   // Start bit edges, old stored value against new written value
   wire              start_new  = avs_writedata[CTL_START_BIT];
   wire              start_old  = ctl_q[CTL_START_BIT];
   wire              start_rise = wr_ctl & ~start_old & start_new;
   wire              start_fall = wr_ctl & start_old & ~start_new;

   // Pin configuration decode
   wire [2:0]        pcfg       = ctl_q[CTL_PCFG_LSB +: 3];
   wire [2:0]        pcfg_new   = ctl_d[CTL_PCFG_LSB +: 3];
   wire              pwr_new    = (pcfg_new != 3'b000);
   wire [3:0]        mask_new   = pcfg_new[2]         ? 4'hf :
                                  (pcfg_new == 3'b011) ? 4'h7 :
                                  (pcfg_new == 3'b010) ? 4'h3 :
                                  (pcfg_new == 3'b001) ? 4'h1 : 4'h0;
   wire              powered    = (pcfg != 3'b000);

   // Conversion clock selection; the undefined code falls back to the fastest divider
   wire [5:0]        div_lim    = (div_sel_q == 2'b01) ? DIV_BY_8 :
                                  (div_sel_q == 2'b10) ? DIV_BY_32 : DIV_BY_2;
   wire              tad_tick   = (div_cnt_q == div_lim - 6'h01);
   wire              running    = (state_q != ADCSQ_IDLE);

   // Sequencer events
   wire              smp_end    = (state_q == ADCSQ_SAMPLE) & tad_tick & (tad_q == SAMPLE_TAD - 7'h01);
   wire              bit_end    = (state_q == ADCSQ_CONVERT) & tad_tick & (sub_q == BIT_TAD);
   wire              conv_done  = (state_q == ADCSQ_FINISH) & tad_tick & (tad_q == TOTAL_TAD - 7'h01);

   // Trial word after the current bit is resolved
   wire [RES_W-1:0]  keep_mask  = ~(RES_W'(1) << bit_q);
   wire [RES_W-1:0]  resolved   = cmp_above ? sar_q : (sar_q & keep_mask);
   wire [RES_W-1:0]  next_trial = (bit_q == 4'h0) ? resolved : (resolved | (RES_W'(1) << (bit_q - 4'h1)));

   // Read data mux; narrow registers sit in the low bits
   wire [7:0]        rd_ctl     = ctl_q;
   wire [7:0]        rd_clk     = {test_bit_q, 5'h00, div_sel_q};
   wire [7:0]        rd_hi      = result_q[RES_W-1:1];
   wire [7:0]        rd_lo      = {result_q[0], 7'h00};
   wire [7:0]        rd_irq     = {5'h00, irq_req_q, irq_gen_q, irq_en_q};
   wire [7:0]        rd_byte    = hit_lo  ? rd_lo  :
                                  hit_hi  ? rd_hi  :
                                  hit_ctl ? rd_ctl :
                                  hit_clk ? rd_clk :
                                  hit_irq ? rd_irq : 8'h00;

   // Next control value: software owns all but the completion flag
   always_comb begin
      ctl_d = ctl_q;
      if (wr_ctl) begin
         ctl_d[CTL_START_BIT] = avs_writedata[CTL_START_BIT];
         ctl_d[5:0]           = avs_writedata[5:0];
      end
      if (start_rise) begin
         ctl_d[CTL_FLAG_BIT] = 1'b1;
      end else if (conv_done) begin
         ctl_d[CTL_FLAG_BIT] = 1'b0;
      end
   end

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ADCSQ_IDLE: begin
            // Falling start edge launches a conversion
            if (start_fall & powered) begin
               state_d = ADCSQ_SAMPLE;
            end
         end
         ADCSQ_SAMPLE: begin
            if (smp_end) begin
               state_d = ADCSQ_CONVERT;
            end
         end
         ADCSQ_CONVERT: begin
            if (bit_end & (bit_q == 4'h0)) begin
               state_d = ADCSQ_FINISH;
            end
         end
         ADCSQ_FINISH: begin
            if (conv_done) begin
               state_d = ADCSQ_IDLE;
            end
         end
      endcase
      // A rising start edge or a power-down aborts whatever runs
      if (start_rise | ~powered) begin
         state_d = ADCSQ_IDLE;
      end
   end

   // Bus handshake: one wait cycle, then the access completes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= ~((avs_read | avs_write) & wait_q);
         // Unmapped addresses read as zero, writes to them are dropped
         if ((avs_read | avs_write) & wait_q) begin
            rdata_q <= {24'h000000, rd_byte};
         end
      end
   end

   // Control register; results are never written by software
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_q <= CTL_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // Clock setting register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_sel_q  <= DIV_RESET;
         test_bit_q <= 1'b0;
      end else if (wr_clk) begin
         div_sel_q  <= avs_writedata[1:0];
         test_bit_q <= avs_writedata[7];
      end
   end

   // Interrupt enables and request; a completion beats a software clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_en_q  <= 1'b0;
         irq_gen_q <= 1'b0;
         irq_req_q <= 1'b0;
      end else begin
         if (wr_irq) begin
            irq_en_q  <= avs_writedata[IRQ_EN_BIT];
            irq_gen_q <= avs_writedata[IRQ_GEN_BIT];
         end
         if (conv_done) begin
            irq_req_q <= 1'b1;
         end else if (wr_irq & ~avs_writedata[IRQ_REQ_BIT]) begin
            irq_req_q <= 1'b0;
         end
      end
   end

   // Conversion clock divider, restarted with each conversion for even timing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_cnt_q <= 6'h00;
      end else if (~running | tad_tick) begin
         div_cnt_q <= 6'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // Period count since start of conversion
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tad_q <= 7'h00;
      end else if (~running) begin
         tad_q <= 7'h00;
      end else if (tad_tick) begin
         tad_q <= tad_q + 7'h01;
      end
   end

   // Sequencer state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ADCSQ_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Bit trials: most significant first, four periods each
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sar_q <= '0;
         bit_q <= 4'h0;
         sub_q <= 2'h0;
      end else if (smp_end) begin
         sar_q <= RES_W'(1) << (RES_W - 1);
         bit_q <= 4'(RES_W - 1);
         sub_q <= 2'h0;
      end else if (bit_end) begin
         sar_q <= next_trial;
         sub_q <= 2'h0;
         if (bit_q != 4'h0) begin
            bit_q <= bit_q - 4'h1;
         end
      end else if ((state_q == ADCSQ_CONVERT) & tad_tick) begin
         sub_q <= sub_q + 2'h1;
      end
   end

   // Result registers load only on completion
   always_ff @(posedge core_clk) begin
      if (rst) begin
         result_q <= RES_RESET;
      end else if (conv_done) begin
         result_q <= sar_q;
      end
   end

   // Pin and power outputs follow the pin configuration
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwr_q      <= 1'b0;
         pin_mask_q <= 4'h0;
      end else begin
         pwr_q      <= pwr_new;
         pin_mask_q <= mask_new;
      end
   end

   // Gated interrupt output
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_req_q & irq_en_q & irq_gen_q;
      end
   end

   // Output drive, all from flip-flops except sample_hold, decoded from state_q
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign adc_power_on    = pwr_q;
   assign analog_sel      = ctl_q[CTL_SEL_LSB +: 2];
   assign sample_hold     = (state_q == ADCSQ_SAMPLE);
   assign trial_code      = sar_q;
   assign analog_pin_mask = pin_mask_q;
   assign conv_irq        = irq_q;

endmodule // adcsq_top

// >>> rtl/adcsq_pkg.sv
// Constants, register map and state encodings for the converter sequencer
// Contract
// - Control bits 1:0 pick analog input 0..3
// - Control bits 5:3 set analog pin count
// - Pin config 000 powers converter off
// - Control bit 6 low means conversion done
// - Start rising edge resets, sets flag one
// - Start high then low launches a conversion
// - Clock bits 1:0 divide system clock 2/8/32
// - Clock bits 6:2 always read zero
// - Sample 32 periods, finish at 76
// - Request flag gated by two enables; writing 0 clears
// - Conversion end clears flag, raises request
// - Result bits 8:1 high byte, bit0 low.7
// - Analog pins lose digital and pull-high
package adcsq_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RESULT_LOW    = 8'h20;
   localparam logic [7:0] IDX_RESULT_HIGH   = 8'h21;
   localparam logic [7:0] IDX_CONTROL       = 8'h22;
   localparam logic [7:0] IDX_CLOCK_SETTING = 8'h23;
   localparam logic [7:0] IDX_IRQ_CTRL      = 8'h24;

   // Control register field positions
   localparam int CTL_SEL_LSB   = 0;
   localparam int CTL_PCFG_LSB  = 3;
   localparam int CTL_FLAG_BIT  = 6;
   localparam int CTL_START_BIT = 7;

   // Interrupt control register field positions
   localparam int IRQ_EN_BIT  = 0;
   localparam int IRQ_GEN_BIT = 1;
   localparam int IRQ_REQ_BIT = 2;

   // Values after reset
   localparam logic [7:0] CTL_RESET   = 8'h40;
   localparam logic [1:0] DIV_RESET   = 2'h0;
   localparam logic [8:0] RES_RESET   = 9'h000;

   // Conversion clock dividers in system clocks per conversion period
   localparam logic [5:0] DIV_BY_2  = 6'h02;
   localparam logic [5:0] DIV_BY_8  = 6'h08;
   localparam logic [5:0] DIV_BY_32 = 6'h20;

   // Conversion timing in conversion periods
   localparam logic [6:0] SAMPLE_TAD = 7'h20;
   localparam logic [6:0] TOTAL_TAD  = 7'h4c;
   localparam logic [1:0] BIT_TAD    = 2'h3;   // Last sub-period of a 4-period bit

   // Sequencer states
   typedef enum logic [1:0] {
      ADCSQ_IDLE    = 2'b00,
      ADCSQ_SAMPLE  = 2'b01,
      ADCSQ_CONVERT = 2'b10,
      ADCSQ_FINISH  = 2'b11
   } adcsq_state_t;

endpackage

// >>> sim/adcsq_properties.sv
// Port-level checks for the converter sequencer
`timescale 1ns/1ps
module adcsq_properties
   import adcsq_pkg::*;
#(
   parameter int RES_W = 9                          // Result width
) (
   // Clock and reset
   input wire logic             core_clk,
   input wire logic             rst,
   // Register bus
   input wire logic [9:0]       avs_address,
   input wire logic             avs_read,
   input wire logic             avs_write,
   input wire logic [31:0]      avs_writedata,
   input wire logic [31:0]      avs_readdata,
   input wire logic             avs_waitrequest,
   // Analog side
   input wire logic             cmp_above,
   input wire logic             adc_power_on,
   input wire logic [1:0]       analog_sel,
   input wire logic             sample_hold,
   input wire logic [RES_W-1:0] trial_code,
   input wire logic [3:0]       analog_pin_mask,
   input wire logic             conv_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire logic        done_w = avs_write && !avs_waitrequest;       // Write takes effect
   wire logic        ctl_w  = done_w && avs_address == 10'h088;    // Control write
   wire logic [2:0]  pc_w   = avs_writedata[5:3];                  // Pin config written
   wire logic [3:0]  mask_w = {pc_w[2], pc_w[2] | (&pc_w[1:0]), pc_w[2] | pc_w[1], |pc_w};
   logic      [1:0]  en_q;                                         // Shadow of both enables
   logic      [1:0]  div_q;                                        // Shadow of clock code
   logic      [10:0] sh_q;                                         // Sampling cycles so far
   // Code 3 behaves as /2, so it shares the short span
   wire logic [10:0] sh_exp = (div_q == 2'h1) ? 11'h100 : (div_q == 2'h2) ? 11'h400 : 11'h040;
   // Shadow registers; a clock change mid-run would skew the span check
   always_ff @(posedge core_clk) begin
      if (rst) begin
         en_q  <= 2'h0;
         div_q <= 2'h0;
         sh_q  <= 11'h000;
      end else begin
         if (done_w && avs_address == 10'h090) en_q <= avs_writedata[1:0];
         if (done_w && avs_address == 10'h08c) div_q <= avs_writedata[1:0];
         sh_q <= sample_hold ? sh_q + 11'h001 : 11'h000;
      end
   end
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   // Bit 7 is a stored test bit, so only bits 6:2 and bits 31:8 must be zero
   clk_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 10'h08c |-> ((avs_readdata[31:8] == 24'h0) && (avs_readdata[6:2] == 5'h0)))
      else $error("clock setting spare bits set");
   power_cfg_a: assert property (ctl_w |-> ##2 (adc_power_on == ($past(pc_w, 2) != 3'h0)))
      else $error("power does not follow pin config");
   pin_mask_a: assert property (ctl_w |-> ##2 (analog_pin_mask == $past(mask_w, 2)))
      else $error("pin mask wrong");
   input_sel_a: assert property (ctl_w |-> ##2 (analog_sel == $past(avs_writedata[1:0], 2)))
      else $error("input select wrong");
   irq_gate_a: assert property (conv_irq |-> $past(en_q) == 2'h3)
      else $error("request passed a closed enable");
   sample_len_a: assert property ($fell(sample_hold) |-> sh_q == sh_exp)
      else $error("sampling span wrong");
   hold_power_a: assert property (sample_hold |-> adc_power_on)
      else $error("sampling while powered off");
   cover property ($fell(sample_hold));
   cover property ($rose(conv_irq));
   cover property (ctl_w && avs_writedata[7]);
endmodule // adcsq_properties

bind adcsq_top adcsq_properties #(.RES_W(RES_W)) adcsq_properties_i (
   .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .cmp_above(cmp_above), .adc_power_on(adc_power_on),
   .analog_sel(analog_sel), .sample_hold(sample_hold), .trial_code(trial_code),
   .analog_pin_mask(analog_pin_mask), .conv_irq(conv_irq));

// >>> sim/adcsq_analog_model.sv
// Sensor levels and comparator facing the converter
`timescale 1ns/1ps
module adcsq_analog_model (
   // Clock
   input wire logic        core_clk,
   // Four sensor levels, nine bits each
   input wire logic [35:0] levels,
   // Converter side
   input wire logic        adc_power_on,
   input wire logic [1:0]  analog_sel,
   input wire logic        sample_hold,
   input wire logic [8:0]  trial_code,
   output logic            cmp_above
);
   logic [8:0] held_q = 9'h000;   // Level caught while sampling
   logic       tog_q  = 1'b0;     // Junk pattern while unpowered
   // Track the selected input only while the switch is closed
   always_ff @(posedge core_clk) begin
      tog_q <= !tog_q;
      if (sample_hold) begin
         held_q <= levels[analog_sel*9 +: 9];
      end
   end
   // Unpowered comparator gives no stable answer
   assign cmp_above = adc_power_on ? (held_q >= trial_code) : tog_q;
endmodule // adcsq_analog_model

// >>> sim/adcsq_tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module adcsq_tb_top;
   import adcsq_pkg::*;
   // Design ports
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  avs_address = 10'h000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cmp_above, adc_power_on, sample_hold, conv_irq;
   logic [1:0]  analog_sel;
   logic [8:0]  trial_code;
   logic [3:0]  analog_pin_mask;
   // Bench state
   logic [35:0] levels = 36'h0;   // Sensor levels
   logic [7:0]  q;                // Last byte read
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;          // Free-running cycle count
   // Clock and cycle count
   always #2.5 core_clk = !core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   adcsq_top adcsq_top_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmp_above(cmp_above), .adc_power_on(adc_power_on),
      .analog_sel(analog_sel), .sample_hold(sample_hold), .trial_code(trial_code),
      .analog_pin_mask(analog_pin_mask), .conv_irq(conv_irq));
   adcsq_analog_model adcsq_analog_model_i (.core_clk(core_clk), .levels(levels), .adc_power_on(adc_power_on),
      .analog_sel(analog_sel), .sample_hold(sample_hold), .trial_code(trial_code), .cmp_above(cmp_above));
   // Conversion length in system clocks for clock codes 0 to 2
   function automatic int span(input logic [1:0] dv);
      return 76 << (2 * dv + 1);
   endfunction
   // Expected nine-bit result: the comparator keeps every bit
   function automatic logic [8:0] exp_res(input logic [1:0] sel);
      return levels[sel*9 +: 9];
   endfunction
   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= {a, 2'b00};
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= {24'h0, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Read and compare
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask
   // Start pulse, poll the flag, check span, result and request
   task automatic convert(input logic [1:0] sel, input logic [2:0] pc, input logic [1:0] dv,
                          input logic [1:0] en, input logic abort);
      int         t0;
      logic [8:0] r;
      bus(1'b1, IDX_CLOCK_SETTING, {6'h0, dv});
      bus(1'b1, IDX_IRQ_CTRL, {6'h0, en});
      rd_chk(IDX_IRQ_CTRL, {6'h0, en});
      bus(1'b1, IDX_CONTROL, {2'b10, pc, 1'b0, sel});
      rd_chk(IDX_CONTROL, {2'b11, pc, 1'b0, sel});
      bus(1'b1, IDX_CONTROL, {2'b00, pc, 1'b0, sel});
      t0 = cyc;
      // Abort after sampling; without it the flag would clear by now
      if (abort) begin
         repeat (100) @(posedge core_clk);
         bus(1'b1, IDX_CONTROL, {2'b10, pc, 1'b0, sel});
         repeat (300) @(posedge core_clk);
         rd_chk(IDX_CONTROL, {2'b11, pc, 1'b0, sel});
         bus(1'b1, IDX_CONTROL, {2'b00, pc, 1'b0, sel});
         t0 = cyc;
      end
      do bus(1'b0, IDX_CONTROL, 8'h00); while (q[6] !== 1'b0);
      // Levels were set by a non-blocking assignment, so read them only now
      r = exp_res(sel);
      `CHK(cyc - t0 >= span(dv) && cyc - t0 <= span(dv) + 12, 1'b1)
      `CHK(conv_irq, en[0] & en[1])
      rd_chk(IDX_RESULT_HIGH, r[8:1]);
      rd_chk(IDX_RESULT_LOW, {r[0], 7'h00});
      rd_chk(IDX_IRQ_CTRL, {5'h0, 1'b1, en});
      bus(1'b1, IDX_RESULT_HIGH, ~r[8:1]);
      rd_chk(IDX_RESULT_HIGH, r[8:1]);
   endtask
   // Verdict and end of run
   task automatic give_verdict;
      if (err_total == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      void'($urandom(17));
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(IDX_CONTROL, CTL_RESET);
      rd_chk(IDX_CLOCK_SETTING, 8'h00);
      rd_chk(IDX_RESULT_HIGH, 8'h00);
      rd_chk(IDX_IRQ_CTRL, 8'h00);
      bus(1'b1, IDX_CLOCK_SETTING, 8'h7f);
      rd_chk(IDX_CLOCK_SETTING, 8'h03);
      bus(1'b1, 8'h25, 8'hff);
      rd_chk(8'h25, 8'h00);
      // Pin config 000: powered off, a start pulse launches nothing
      bus(1'b1, IDX_CONTROL, 8'h81);
      bus(1'b1, IDX_CONTROL, 8'h01);
      repeat (200) @(posedge core_clk);
      rd_chk(IDX_CONTROL, 8'h41);
      `CHK(adc_power_on, 1'b0)
      // Every input and clock codes 0 to 2, random levels, enables and configs
      for (int i = 0; i < 12; i++) begin
         levels <= 36'({$urandom, $urandom});
         convert(2'(i), (i < 4) ? 3'(i + 1) : 3'($urandom_range(7, 1)),
                 (i < 3) ? 2'(i) : (i == 5) ? 2'h0 : 2'($urandom_range(2)), 2'($urandom), i == 5);
      end
      give_verdict();
   end
   // Watchdog against a hung handshake or flag
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      give_verdict();
   end
endmodule // adcsq_tb_top
